/* File: hw/serial_channel_pkg.sv */
// Constants, field layouts and carrier types of the serial channel
// interrupt, error and autobaud write-back block.
// Assumes one module clock; every event input is already on that clock.
`default_nettype none

package serial_channel_pkg;

    localparam int DW = 16;
    localparam int AW = 3;
    localparam int BAUD_W = 13;
    localparam int NUM_IRQ = 6;

    // Register offsets (word index on the plain register port)
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_BAUD = 3'h1;
    localparam logic [2:0] ADDR_AB_CTRL = 3'h2;
    localparam logic [2:0] ADDR_AB_STAT = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
    localparam logic [2:0] ADDR_FIFO_CTRL = 3'h6;

    // serial_control_reg fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ODD_BIT = 3;
    localparam int CTRL_FCHK_BIT = 4;
    localparam int CTRL_PCHK_BIT = 5;
    localparam int CTRL_OCHK_BIT = 6;
    localparam int CTRL_FERR_BIT = 8;
    localparam int CTRL_PERR_BIT = 9;
    localparam int CTRL_OERR_BIT = 10;

    // autobaud control fields, autobaud_status_reg fields
    localparam int AB_UNIT_BIT = 0;
    localparam int AB_FOUND_EN_BIT = 1;
    localparam int AB_START_EN_BIT = 2;
    localparam int AB_FIRST_EN_BIT = 3;
    localparam int ABS_START_BIT = 0;
    localparam int ABS_FIRST_BIT = 1;
    localparam int ABS_DONE_BIT = 2;

    // FIFO control fields
    localparam int FIFO_CFG_BIT = 0;
    localparam int FIFO_TRANSP_BIT = 1;
    localparam int FIFO_THR_LSB = 4;

    // Interrupt line indices, shared by status and mask registers
    localparam int IRQ_TX_BUF = 0;
    localparam int IRQ_TX_DONE = 1;
    localparam int IRQ_RX = 2;
    localparam int IRQ_ERR = 3;
    localparam int IRQ_AB_START = 4;
    localparam int IRQ_AB_FOUND = 5;

    localparam logic [1:0] PULSE_LEN = 2'h2;

    localparam logic [2:0] MODE_SYNC = 3'h0;
    localparam logic [2:0] MODE_ASYNC8 = 3'h1;
    localparam logic [2:0] MODE_ASYNC7P = 3'h3;
    localparam logic [2:0] MODE_ASYNC8P = 3'h7;

    localparam logic [DW-1:0] CTRL_RESET = 16'h0000;
    localparam logic [BAUD_W-1:0] BAUD_RESET = 13'h0000;

    localparam logic [BAUD_W-1:0] RELOAD_TAB [9] = '{
        13'h0002, 13'h0005, 13'h000B, 13'h0011, 13'h0023,
        13'h0047, 13'h008F, 13'h011F, 13'h023F};

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          we;
        logic          re;
    } bus_req_type;

    typedef struct packed {
        logic       done;
        logic       stop_low;
        logic       par_bit;
        logic [7:0] data;
    } rx_event_type;

    typedef struct packed {
        logic       buf_move;
        logic       before_last;
        logic       after_last;
        logic [3:0] fifo_level;
    } tx_event_type;

    typedef struct packed {
        logic       start_bit;
        logic       first_char;
        logic       done;
        logic [2:0] fmt;
        logic [3:0] baud;
    } ab_event_type;

endpackage

`default_nettype wire

/* File: hw/serial_irq_err_ab.sv */
// Interrupt pulses, receive error flags and autobaud write-back of one
// serial channel, with its registers on a plain register port.
// Assumes the shift datapath and autobaud detector on the same clock
// give one-cycle event pulses; no input needs synchronising.
`default_nettype none

// Function
// - After autobaud success, overwrite mode field, parity select and 13-bit reload.
// - Format 7E->011/0, 7O->011/1, 8E->111/0, 8O->111/1, 8N->001/0.
// - Baud indices 0..8 load 2,5,11,17,35,71,143,287,575.
// - Async, framing check on, stop bit low sets framing error flag.
// - Async parity modes, parity check on, mismatch sets parity error flag.
// - Overrun check on, frame done while buffer unread sets overrun flag.
// - Error interrupt rises in same cycle as receive interrupt.
// - Each of six interrupt lines stays high two clock periods after its last event.
// - Error flags stay set after the pulse until software clears them.
// - Transmit buffer interrupt when word moves into transmit shift register.
// - Transmit interrupt before last async bit, after last sync bit.
// - Receive interrupt when frame moves into receive buffer.
// - Autobaud start interrupt per start bit while all three enables set.
// - Autobaud found interrupt after second char, first too if enabled.
// - Both autobaud interrupt lines OR into one request.
// - FIFO on, not transparent: transmit buffer and async transmit interrupts follow fill threshold.
module serial_irq_err_ab (
    input  wire logic                               sys_clk_in,
    input  wire logic                               rst_b_in,
    input  wire serial_channel_pkg::bus_req_type    bus_in,
    output logic [serial_channel_pkg::DW-1:0]       rd_data_out,
    input  wire serial_channel_pkg::rx_event_type   rx_evt_in,
    input  wire logic                               rx_buf_read_in,
    input  wire serial_channel_pkg::tx_event_type   tx_evt_in,
    input  wire serial_channel_pkg::ab_event_type   ab_evt_in,
    output logic [2:0]                              mode_out,
    output logic                                    parity_odd_out,
    output logic [serial_channel_pkg::BAUD_W-1:0]   baud_reload_value_out,
    output logic                                    tx_buf_irq_out,
    output logic                                    tx_done_irq_out,
    output logic                                    rx_irq_out,
    output logic                                    err_irq_out,
    output logic                                    autobaud_start_irq_out,
    output logic                                    autobaud_found_irq_out,
    output logic                                    autobaud_irq_out,
    output logic                                    irq_out
);

    typedef struct packed {
        logic [15:0] ctrl;
        logic [12:0] baud;
        logic [3:0]  ab_ctrl;
        logic [2:0]  ab_stat;
        logic [7:0]  fifo_ctrl;
        logic [5:0]  irq_stat;
        logic [5:0]  irq_mask;
        logic        rx_full;
        logic [3:0]  lvl_prev;
        logic [11:0] cnt;
        logic [5:0]  pulse;
        logic        ab_irq;
        logic        irq;
        logic [15:0] rdata;
    } state_type;

    state_type st_q;
    state_type st_d;

    // {mode, odd} for a detected frame format index
    function automatic logic [3:0] fmt_code(input logic [2:0] fmt);
        logic [3:0] r;
        r = {serial_channel_pkg::MODE_ASYNC8, 1'b0};
        unique case (fmt)
            3'h0: r = {serial_channel_pkg::MODE_ASYNC7P, 1'b0};
            3'h1: r = {serial_channel_pkg::MODE_ASYNC7P, 1'b1};
            3'h2: r = {serial_channel_pkg::MODE_ASYNC8P, 1'b0};
            3'h3: r = {serial_channel_pkg::MODE_ASYNC8P, 1'b1};
            default: r = {serial_channel_pkg::MODE_ASYNC8, 1'b0};
        endcase
        return r;
    endfunction

    // Out-of-range index keeps the present reload rather than guess
    function automatic logic [12:0] reload_for(input logic [3:0] idx,
                                               input logic [12:0] cur);
        logic [12:0] r;
        r = cur;
        if (idx <= 4'h8) begin
            r = serial_channel_pkg::RELOAD_TAB[idx];
        end
        return r;
    endfunction

    // Parity over 7 or 8 data bits plus the received parity bit
    function automatic logic parity_bad(input logic [2:0] mode,
                                        input logic odd,
                                        input logic [7:0] data,
                                        input logic pbit);
        logic ones;
        ones = (mode == serial_channel_pkg::MODE_ASYNC7P) ? ^data[6:0] : ^data;
        return (ones ^ pbit) != odd;
    endfunction

    logic [5:0] ev;
    logic       async_mode;
    logic       par_mode;
    logic       fifo_thr_mode;
    logic       thr_hit;
    logic       ferr;
    logic       perr;
    logic       oerr;
    logic       rd_hit;
    logic       wr_hit;
    logic [3:0] thr;
    logic [3:0] fc;

    always_comb begin
        st_d = st_q;
        ev = '0;
        fc = '0;
        thr = st_q.fifo_ctrl[serial_channel_pkg::FIFO_THR_LSB +: 4];
        async_mode = st_q.ctrl[2:0] != serial_channel_pkg::MODE_SYNC;
        par_mode = (st_q.ctrl[2:0] == serial_channel_pkg::MODE_ASYNC7P) ||
                   (st_q.ctrl[2:0] == serial_channel_pkg::MODE_ASYNC8P);
        fifo_thr_mode = st_q.fifo_ctrl[serial_channel_pkg::FIFO_CFG_BIT] &&
                        !st_q.fifo_ctrl[serial_channel_pkg::FIFO_TRANSP_BIT];
        // Crossing down to the threshold, so a steady level fires once
        thr_hit = (st_q.lvl_prev > thr) && (tx_evt_in.fifo_level <= thr);
        st_d.lvl_prev = tx_evt_in.fifo_level;

        ferr = rx_evt_in.done && async_mode && rx_evt_in.stop_low &&
               st_q.ctrl[serial_channel_pkg::CTRL_FCHK_BIT];
        perr = rx_evt_in.done && async_mode && par_mode &&
               st_q.ctrl[serial_channel_pkg::CTRL_PCHK_BIT] &&
               parity_bad(st_q.ctrl[2:0], st_q.ctrl[serial_channel_pkg::CTRL_ODD_BIT],
                          rx_evt_in.data, rx_evt_in.par_bit);
        oerr = rx_evt_in.done && st_q.rx_full &&
               st_q.ctrl[serial_channel_pkg::CTRL_OCHK_BIT];

        // Interrupt events of this cycle
        if (fifo_thr_mode) begin
            ev[serial_channel_pkg::IRQ_TX_BUF] = thr_hit;
        end else begin
            ev[serial_channel_pkg::IRQ_TX_BUF] = tx_evt_in.buf_move;
        end
        if (!async_mode) begin
            ev[serial_channel_pkg::IRQ_TX_DONE] = tx_evt_in.after_last;
        end else if (fifo_thr_mode) begin
            ev[serial_channel_pkg::IRQ_TX_DONE] = tx_evt_in.before_last &&
                (tx_evt_in.fifo_level <= thr);
        end else begin
            ev[serial_channel_pkg::IRQ_TX_DONE] = tx_evt_in.before_last;
        end
        ev[serial_channel_pkg::IRQ_RX] = rx_evt_in.done;
        ev[serial_channel_pkg::IRQ_ERR] = ferr || perr || oerr;
        ev[serial_channel_pkg::IRQ_AB_START] = ab_evt_in.start_bit &&
            st_q.ab_ctrl[serial_channel_pkg::AB_UNIT_BIT] &&
            st_q.ab_ctrl[serial_channel_pkg::AB_FOUND_EN_BIT] &&
            st_q.ab_ctrl[serial_channel_pkg::AB_START_EN_BIT];
        ev[serial_channel_pkg::IRQ_AB_FOUND] = ab_evt_in.done ||
            (ab_evt_in.first_char &&
             st_q.ab_ctrl[serial_channel_pkg::AB_FIRST_EN_BIT]);

        // Two-period pulse per line; a new event restarts the count
        for (int i = 0; i < serial_channel_pkg::NUM_IRQ; i++) begin
            if (ev[i]) begin
                st_d.cnt[2*i +: 2] = serial_channel_pkg::PULSE_LEN;
            end else if (st_q.cnt[2*i +: 2] != 2'h0) begin
                st_d.cnt[2*i +: 2] = st_q.cnt[2*i +: 2] - 2'h1;
            end
            st_d.pulse[i] = ev[i] || (st_q.cnt[2*i +: 2] > 2'h1);
        end
        st_d.ab_irq = st_d.pulse[serial_channel_pkg::IRQ_AB_START] ||
                      st_d.pulse[serial_channel_pkg::IRQ_AB_FOUND];

        rd_hit = bus_in.re;
        wr_hit = bus_in.we;

        // Register reads; read data stands one cycle after the strobe
        st_d.rdata = '0;
        if (rd_hit) begin
            unique case (bus_in.addr)
                serial_channel_pkg::ADDR_CTRL: st_d.rdata = st_q.ctrl;
                serial_channel_pkg::ADDR_BAUD: st_d.rdata = {3'h0, st_q.baud};
                serial_channel_pkg::ADDR_AB_CTRL: st_d.rdata = {12'h000, st_q.ab_ctrl};
                serial_channel_pkg::ADDR_AB_STAT: st_d.rdata = {13'h0000, st_q.ab_stat};
                serial_channel_pkg::ADDR_IRQ_STAT: st_d.rdata = {10'h000, st_q.irq_stat};
                serial_channel_pkg::ADDR_IRQ_MASK: st_d.rdata = {10'h000, st_q.irq_mask};
                serial_channel_pkg::ADDR_FIFO_CTRL: st_d.rdata = {8'h00, st_q.fifo_ctrl};
                default: st_d.rdata = '0;
            endcase
            // Read-to-clear status; same-cycle events re-set below
            if (bus_in.addr == serial_channel_pkg::ADDR_IRQ_STAT) begin
                st_d.irq_stat = '0;
            end
            if (bus_in.addr == serial_channel_pkg::ADDR_AB_STAT) begin
                st_d.ab_stat = '0;
            end
        end

        // Register writes
        if (wr_hit) begin
            unique case (bus_in.addr)
                serial_channel_pkg::ADDR_CTRL: begin
                    st_d.ctrl[7:0] = bus_in.wdata[7:0];
                    // Flags only fall where a zero is written
                    st_d.ctrl[10:8] = st_q.ctrl[10:8] & bus_in.wdata[10:8];
                end
                serial_channel_pkg::ADDR_BAUD: st_d.baud = bus_in.wdata[12:0];
                serial_channel_pkg::ADDR_AB_CTRL: st_d.ab_ctrl = bus_in.wdata[3:0];
                serial_channel_pkg::ADDR_IRQ_MASK: st_d.irq_mask = bus_in.wdata[5:0];
                serial_channel_pkg::ADDR_FIFO_CTRL: st_d.fifo_ctrl = bus_in.wdata[7:0];
                default: st_d.ctrl = st_d.ctrl;
            endcase
        end

        // Hardware sets after software clears, so the set wins
        if (ferr) begin
            st_d.ctrl[serial_channel_pkg::CTRL_FERR_BIT] = 1'b1;
        end
        if (perr) begin
            st_d.ctrl[serial_channel_pkg::CTRL_PERR_BIT] = 1'b1;
        end
        if (oerr) begin
            st_d.ctrl[serial_channel_pkg::CTRL_OERR_BIT] = 1'b1;
        end

        // Autobaud result overrides a same-cycle software write
        if (ab_evt_in.done && st_q.ab_ctrl[serial_channel_pkg::AB_UNIT_BIT]) begin
            fc = fmt_code(ab_evt_in.fmt);
            st_d.ctrl[2:0] = fc[3:1];
            st_d.ctrl[serial_channel_pkg::CTRL_ODD_BIT] = fc[0];
            st_d.baud = reload_for(ab_evt_in.baud, st_q.baud);
        end

        if (ab_evt_in.start_bit) begin
            st_d.ab_stat[serial_channel_pkg::ABS_START_BIT] = 1'b1;
        end
        if (ab_evt_in.first_char) begin
            st_d.ab_stat[serial_channel_pkg::ABS_FIRST_BIT] = 1'b1;
        end
        if (ab_evt_in.done) begin
            st_d.ab_stat[serial_channel_pkg::ABS_DONE_BIT] = 1'b1;
        end

        st_d.irq_stat = st_d.irq_stat | ev;
        st_d.irq = |(st_d.irq_stat & st_q.irq_mask);
        if (wr_hit && bus_in.addr == serial_channel_pkg::ADDR_IRQ_MASK) begin
            st_d.irq = |(st_d.irq_stat & bus_in.wdata[5:0]);
        end

        // Receive buffer holds unread data until it is read
        if (rx_evt_in.done) begin
            st_d.rx_full = 1'b1;
        end else if (rx_buf_read_in) begin
            st_d.rx_full = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q <= '0;
            st_q.ctrl <= serial_channel_pkg::CTRL_RESET;
            st_q.baud <= serial_channel_pkg::BAUD_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data_out = st_q.rdata;
    assign mode_out = st_q.ctrl[2:0];
    assign parity_odd_out = st_q.ctrl[serial_channel_pkg::CTRL_ODD_BIT];
    assign baud_reload_value_out = st_q.baud;
    assign tx_buf_irq_out = st_q.pulse[serial_channel_pkg::IRQ_TX_BUF];
    assign tx_done_irq_out = st_q.pulse[serial_channel_pkg::IRQ_TX_DONE];
    assign rx_irq_out = st_q.pulse[serial_channel_pkg::IRQ_RX];
    assign err_irq_out = st_q.pulse[serial_channel_pkg::IRQ_ERR];
    assign autobaud_start_irq_out = st_q.pulse[serial_channel_pkg::IRQ_AB_START];
    assign autobaud_found_irq_out = st_q.pulse[serial_channel_pkg::IRQ_AB_FOUND];
    assign autobaud_irq_out = st_q.ab_irq;
    assign irq_out = st_q.irq;

endmodule

`default_nettype wire

/* File: test/remote_station_model.sv */
// Far-side station: frame completions, transmit progress and autobaud events.
// Assumes the caller waits for each task; fields turn over once released.
`default_nettype none

module remote_station_model (
    input  wire logic                         clk_in,
    output var serial_channel_pkg::rx_event_type  rx_evt_out,
    output var serial_channel_pkg::tx_event_type  tx_evt_out,
    output var serial_channel_pkg::ab_event_type  ab_evt_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_evt_out = '0;
        tx_evt_out = '0;
        ab_evt_out = '0;
    end
    // Released fields are inverted so stale values are never trusted
    task automatic rx_frame(input logic [7:0] d, input logic p, input logic s);
        @(posedge clk_in);
        rx_evt_out <= {1'b1, s, p, d};
        @(posedge clk_in);
        rx_evt_out <= {1'b0, ~s, ~p, ~d};
    endtask
    task automatic tx_evt(input logic [2:0] k);
        @(posedge clk_in);
        tx_evt_out <= {k, tx_evt_out.fifo_level};
        @(posedge clk_in);
        tx_evt_out <= {3'h0, tx_evt_out.fifo_level};
    endtask
    task automatic set_level(input logic [3:0] l);
        @(posedge clk_in);
        tx_evt_out.fifo_level <= l;
        @(posedge clk_in);
    endtask
    task automatic ab_evt(input logic [2:0] k, input logic [2:0] f, input logic [3:0] b);
        @(posedge clk_in);
        ab_evt_out <= {k, f, b};
        @(posedge clk_in);
        ab_evt_out <= {3'h0, ~f, ~b};
    endtask
endmodule

`default_nettype wire

/* File: test/serial_irq_err_ab_sva.sv */
// Concurrent checks on the serial interrupt, error and autobaud block.
// Assumes a single clock and event pulses sampled on its rising edge.
`default_nettype none

module serial_irq_err_ab_sva (
    input wire logic                             sys_clk_in,
    input wire logic                             rst_b_in,
    input wire serial_channel_pkg::rx_event_type rx_evt_in,
    input wire serial_channel_pkg::ab_event_type ab_evt_in,
    input wire logic                             rx_irq_out,
    input wire logic                             err_irq_out,
    input wire logic                             autobaud_start_irq_out,
    input wire logic                             autobaud_found_irq_out,
    input wire logic                             autobaud_irq_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    AST_ERR_WITH_RX: assert property (err_irq_out |-> rx_irq_out)
        else $error("error pulse without receive pulse");
    AST_RX_PULSE: assert property (rx_evt_in.done |=> rx_irq_out [*2])
        else $error("receive pulse not two cycles");
    AST_RX_QUIET: assert property (!rx_evt_in.done ##1 !rx_evt_in.done |=> !rx_irq_out)
        else $error("receive pulse too long");
    AST_ERR_QUIET: assert property (!rx_evt_in.done ##1 !rx_evt_in.done |=> !err_irq_out)
        else $error("error pulse too long");
    AST_AB_OR: assert property (autobaud_irq_out == (autobaud_start_irq_out || autobaud_found_irq_out))
        else $error("autobaud request is not the OR");
    AST_AB_FOUND: assert property (ab_evt_in.done |=> autobaud_found_irq_out [*2])
        else $error("found pulse missing after detection");
    AST_FOUND_QUIET: assert property ((!ab_evt_in.done && !ab_evt_in.first_char) ##1
        (!ab_evt_in.done && !ab_evt_in.first_char) |=> !autobaud_found_irq_out)
        else $error("found pulse too long");
    AST_START_QUIET: assert property (!ab_evt_in.start_bit ##1 !ab_evt_in.start_bit
        |=> !autobaud_start_irq_out)
        else $error("start pulse without start bit");
endmodule

bind serial_irq_err_ab serial_irq_err_ab_sva i_sva (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .rx_evt_in(rx_evt_in),
    .ab_evt_in(ab_evt_in), .rx_irq_out(rx_irq_out), .err_irq_out(err_irq_out),
    .autobaud_start_irq_out(autobaud_start_irq_out),
    .autobaud_found_irq_out(autobaud_found_irq_out), .autobaud_irq_out(autobaud_irq_out));

`default_nettype wire

/* File: test/uart_irq_error_autobaud_update_tb.sv */
// Register-port tests of the serial interrupt, error and autobaud block.
// Assumes the far-side model drives all event inputs.
`default_nettype none

`define CMP(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module uart_irq_error_autobaud_update_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in, rst_b_in, rx_buf_read_in, irq_out, ab_irq;
    logic mode_odd;
    logic [2:0] mode;
    logic [12:0] reload;
    logic [15:0] rdata, v;
    logic [5:0] irqs;
    serial_channel_pkg::bus_req_type  bus;
    serial_channel_pkg::rx_event_type rx_evt;
    serial_channel_pkg::tx_event_type tx_evt;
    serial_channel_pkg::ab_event_type ab_evt;
    int failures, check_count;
    logic [12:0] rl [9] = '{13'h0002, 13'h0005, 13'h000b, 13'h0011, 13'h0023,
                            13'h0047, 13'h008f, 13'h011f, 13'h023f};
    logic [2:0] md [5] = '{3'h3, 3'h3, 3'h7, 3'h7, 3'h1};
    logic [4:0] od = 5'h0a;

    serial_irq_err_ab i_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .bus_in(bus),
        .rd_data_out(rdata), .rx_evt_in(rx_evt), .rx_buf_read_in(rx_buf_read_in),
        .tx_evt_in(tx_evt), .ab_evt_in(ab_evt), .mode_out(mode), .parity_odd_out(mode_odd),
        .baud_reload_value_out(reload), .tx_buf_irq_out(irqs[0]), .tx_done_irq_out(irqs[1]),
        .rx_irq_out(irqs[2]), .err_irq_out(irqs[3]), .autobaud_start_irq_out(irqs[4]),
        .autobaud_found_irq_out(irqs[5]), .autobaud_irq_out(ab_irq), .irq_out(irq_out));
    remote_station_model i_peer (.clk_in(sys_clk_in), .rx_evt_out(rx_evt),
        .tx_evt_out(tx_evt), .ab_evt_out(ab_evt));

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        // Read strobe is already low here; only the fields of a write move
        @(posedge sys_clk_in);
        bus.addr <= a;
        bus.wdata <= d;
        bus.we <= 1'b1;
        @(posedge sys_clk_in);
        bus.we <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] r);
        @(posedge sys_clk_in);
        bus.addr <= a;
        bus.re <= 1'b1;
        @(posedge sys_clk_in);
        bus.re <= 1'b0;
        @(negedge sys_clk_in);
        r = rdata;
    endtask
    task automatic chk(input logic [2:0] a, input logic [15:0] e);
        rd(a, v);
        `CMP(v, e)
    endtask
    task automatic rd_buf();
        @(posedge sys_clk_in);
        rx_buf_read_in <= 1'b1;
        @(posedge sys_clk_in);
        rx_buf_read_in <= 1'b0;
    endtask
    // Pulses are looked at mid-cycle so both high cycles and the fall are seen
    task automatic expect_irq(input logic [5:0] e);
        @(negedge sys_clk_in);
        `CMP(irqs, e)
        `CMP(ab_irq, e[4] | e[5])
        @(negedge sys_clk_in);
        `CMP(irqs, e)
        `CMP(ab_irq, e[4] | e[5])
        @(negedge sys_clk_in);
        `CMP(irqs, 6'h00)
        `CMP(ab_irq, 1'b0)
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        #250000;
        failures++;
        print_verdict();
    end
    initial begin
        failures = 0;
        check_count = 0;
        rst_b_in = 1'b0;
        bus = '0;
        rx_buf_read_in = 1'b0;
        repeat (20) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        chk(serial_channel_pkg::ADDR_CTRL, 16'h0000);
        chk(serial_channel_pkg::ADDR_BAUD, 16'h0000);
        wr(serial_channel_pkg::ADDR_AB_CTRL, 16'h0007);
        for (int i = 0; i < 9; i++) begin
            i_peer.ab_evt(3'h1, 3'(i % 5), 4'(i));
            @(negedge sys_clk_in);
            `CMP({mode, mode_odd, reload}, {md[i % 5], od[i % 5], rl[i]})
        end
        chk(serial_channel_pkg::ADDR_BAUD, 16'h023f);
        chk(serial_channel_pkg::ADDR_CTRL, 16'h000f);
        i_peer.ab_evt(3'h4, 3'h0, 4'hf);
        expect_irq(6'h10);
        i_peer.ab_evt(3'h2, 3'h0, 4'hf);
        expect_irq(6'h00);
        wr(serial_channel_pkg::ADDR_AB_CTRL, 16'h000b);
        i_peer.ab_evt(3'h4, 3'h0, 4'hf);
        expect_irq(6'h00);
        i_peer.ab_evt(3'h2, 3'h0, 4'hf);
        expect_irq(6'h20);
        chk(serial_channel_pkg::ADDR_AB_CTRL, 16'h000b);
        chk(serial_channel_pkg::ADDR_AB_STAT, 16'h0007);
        chk(serial_channel_pkg::ADDR_AB_STAT, 16'h0000);
        wr(serial_channel_pkg::ADDR_CTRL, 16'h0051);
        i_peer.rx_frame(8'h55, 1'b0, 1'b1);
        expect_irq(6'h0c);
        chk(serial_channel_pkg::ADDR_CTRL, 16'h0151);
        wr(serial_channel_pkg::ADDR_CTRL, 16'h0151);
        chk(serial_channel_pkg::ADDR_CTRL, 16'h0151);
        wr(serial_channel_pkg::ADDR_CTRL, 16'h0051);
        chk(serial_channel_pkg::ADDR_CTRL, 16'h0051);
        i_peer.rx_frame(8'h55, 1'b0, 1'b0);
        expect_irq(6'h0c);
        chk(serial_channel_pkg::ADDR_CTRL, 16'h0451);
        rd_buf();
        wr(serial_channel_pkg::ADDR_CTRL, 16'h0027);
        i_peer.rx_frame(8'h03, 1'b0, 1'b1);
        expect_irq(6'h04);
        i_peer.rx_frame(8'h01, 1'b0, 1'b0);
        expect_irq(6'h0c);
        chk(serial_channel_pkg::ADDR_CTRL, 16'h0227);
        wr(serial_channel_pkg::ADDR_CTRL, 16'h002f);
        i_peer.rx_frame(8'h01, 1'b0, 1'b0);
        expect_irq(6'h04);
        wr(serial_channel_pkg::ADDR_CTRL, 16'h0070);
        rd_buf();
        i_peer.rx_frame(8'h01, 1'b1, 1'b1);
        expect_irq(6'h04);
        rd(serial_channel_pkg::ADDR_IRQ_STAT, v);
        wr(serial_channel_pkg::ADDR_IRQ_MASK, 16'h0004);
        rd_buf();
        i_peer.rx_frame(8'h00, 1'b0, 1'b0);
        expect_irq(6'h04);
        `CMP(irq_out, 1'b1)
        chk(serial_channel_pkg::ADDR_IRQ_STAT, 16'h0004);
        repeat (2) @(negedge sys_clk_in);
        `CMP(irq_out, 1'b0)
        wr(serial_channel_pkg::ADDR_IRQ_MASK, 16'h0000);
        rd_buf();
        i_peer.rx_frame(8'h00, 1'b0, 1'b0);
        expect_irq(6'h04);
        `CMP(irq_out, 1'b0)
        chk(serial_channel_pkg::ADDR_IRQ_STAT, 16'h0004);
        wr(3'h7, 16'hffff);
        chk(3'h7, 16'h0000);
        chk(serial_channel_pkg::ADDR_IRQ_MASK, 16'h0000);
        // Software side: reload on buffer pulse, confirm end on transmit pulse
        wr(serial_channel_pkg::ADDR_CTRL, 16'h0001);
        i_peer.tx_evt(3'h4);
        expect_irq(6'h01);
        i_peer.tx_evt(3'h2);
        expect_irq(6'h02);
        i_peer.tx_evt(3'h1);
        expect_irq(6'h00);
        wr(serial_channel_pkg::ADDR_CTRL, 16'h0000);
        i_peer.tx_evt(3'h1);
        expect_irq(6'h02);
        i_peer.tx_evt(3'h2);
        expect_irq(6'h00);
        wr(serial_channel_pkg::ADDR_CTRL, 16'h0001);
        wr(serial_channel_pkg::ADDR_FIFO_CTRL, 16'h0041);
        chk(serial_channel_pkg::ADDR_FIFO_CTRL, 16'h0041);
        i_peer.set_level(4'h6);
        expect_irq(6'h00);
        i_peer.tx_evt(3'h4);
        expect_irq(6'h00);
        i_peer.tx_evt(3'h2);
        expect_irq(6'h00);
        i_peer.set_level(4'h3);
        expect_irq(6'h01);
        i_peer.tx_evt(3'h2);
        expect_irq(6'h02);
        print_verdict();
    end
endmodule

`default_nettype wire
